// >>> uart_pkg.sv
// Function
// - Parity fault sets flag; receive-data read clears it.
// - Overrun when new byte lands before read.
// - Receive read clears overrun only if available=0.
// - Missing stop bit sets framing flag; read clears.
// - All-zero frame sets break flag; read clears.
// - Holding-empty shows room; transmit write clears it.
// - Transmitter idle only when shifter empty, sent.
// - Status bit returns clear-to-send input level.
// - Frame-start flag on first byte; read clears.
// - Last multiprocessor bit held; read clears it.
// - Transmit enable, gated by clear-to-send when enabled.
// - Line control bit order; all reset zero.
package uart_pkg;
	localparam int ADR_W = 14;
	localparam int IDX_W = 12;
	localparam logic [IDX_W-1:0] IDX_DATA = 12'hF40;
	localparam logic [IDX_W-1:0] IDX_LINE_STATUS = 12'hF41;
	localparam logic [IDX_W-1:0] IDX_LINE_CONTROL = 12'hF42;
	localparam logic [IDX_W-1:0] IDX_MP_CONTROL = 12'hF43;
	localparam logic [IDX_W-1:0] IDX_FRAME_STATUS = 12'hF44;
	localparam logic [IDX_W-1:0] IDX_DIVISOR = 12'hF45;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'hF46;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'hF47;
	localparam logic [IDX_W-1:0] IDX_UART1_LINE_CONTROL = 12'hF4A;
	localparam logic [IDX_W-1:0] IDX_UART1_FRAME_STATUS = 12'hF4C;
	localparam int CTL_TX_EN = 7;
	localparam int CTL_REN = 6;
	localparam int CTL_FLOW = 5;
	localparam int CTL_PAR_EN = 4;
	localparam int CTL_PAR_SEL = 3;
	localparam int CTL_BREAK = 2;
	localparam int CTL_STOP = 1;
	localparam int CTL_LOOP = 0;
	localparam int LS_AVAIL = 7;
	localparam int LS_PARITY = 6;
	localparam int LS_OVERRUN = 5;
	localparam int LS_FRAMING = 4;
	localparam int LS_BREAK = 3;
	localparam int LS_HOLD_EMPTY = 2;
	localparam int LS_TX_IDLE = 1;
	localparam int LS_CTS = 0;
	localparam int FS_NEW_FRAME = 1;
	localparam int FS_MP_BIT = 0;
	localparam int MP_ENABLE = 0;
	localparam int MP_TX_BIT = 1;
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;
	localparam int IRQ_ERR = 2;
	localparam int IRQ_W = 3;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] DIVISOR_RESET = 16'h043D;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_EXTRA = 3'b011,
		TX_STOP = 3'b100
	} tx_state_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_EXTRA = 3'b011,
		RX_STOP1 = 3'b100,
		RX_STOP2 = 3'b101
	} rx_state_t;
endpackage : uart_pkg

// >>> rx_frame_engine.sv
`timescale 1ns/10ps
module rx_frame_engine (
	input wire logic clk,
	input wire logic rstn,
	input wire logic rxIn,
	input wire logic enable,
	input wire logic [15:0] bitDiv,
	input wire logic parityEn,
	input wire logic paritySel,
	input wire logic twoStop,
	input wire logic mpEn,
	output logic done,
	output logic [7:0] data,
	output logic parityErr,
	output logic frameErr,
	output logic breakSeen,
	output logic mpBit
);
	import uart_pkg::*;
	rx_state_t state_reg;
	logic [15:0] cnt_reg;
	logic [2:0] bitIdx_reg;
	logic [7:0] shift_reg;
	logic extra_reg;
	logic allZero_reg;
	logic stopBad_reg;
	wire tick = (cnt_reg == 16'h0000);
	wire hasExtra = parityEn | mpEn;
	wire zeroNow = allZero_reg & ~rxIn;
	wire parityBad = parityEn & ((^{shift_reg, extra_reg}) != paritySel);
	wire finish = tick & ((state_reg == RX_STOP1 & ~twoStop) | state_reg == RX_STOP2);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= RX_IDLE;
			cnt_reg <= 16'h0000;
			bitIdx_reg <= 3'h0;
			shift_reg <= 8'h00;
			extra_reg <= 1'b0;
			allZero_reg <= 1'b0;
			stopBad_reg <= 1'b0;
		end else if (state_reg == RX_IDLE) begin
			if (enable && !rxIn) begin
				state_reg <= RX_START;
				cnt_reg <= {1'b0, bitDiv[15:1]};
			end
		end else if (!tick) begin
			cnt_reg <= cnt_reg - 16'h0001;
		end else begin
			cnt_reg <= bitDiv;
			allZero_reg <= zeroNow;
			case (state_reg)
				RX_START: begin
					state_reg <= rxIn ? RX_IDLE : RX_DATA;
					bitIdx_reg <= 3'h0;
					allZero_reg <= 1'b1;
					stopBad_reg <= 1'b0;
				end
				RX_DATA: begin
					shift_reg <= {rxIn, shift_reg[7:1]};
					bitIdx_reg <= bitIdx_reg + 3'h1;
					if (bitIdx_reg == 3'h7) begin
						state_reg <= hasExtra ? RX_EXTRA : RX_STOP1;
					end
				end
				RX_EXTRA: begin
					extra_reg <= rxIn;
					state_reg <= RX_STOP1;
				end
				RX_STOP1: begin
					stopBad_reg <= ~rxIn;
					state_reg <= twoStop ? RX_STOP2 : RX_IDLE;
				end
				default: begin
					state_reg <= RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done <= 1'b0;
			data <= 8'h00;
			parityErr <= 1'b0;
			frameErr <= 1'b0;
			breakSeen <= 1'b0;
			mpBit <= 1'b0;
		end else begin
			done <= finish;
			if (finish) begin
				data <= shift_reg;
				parityErr <= parityBad;
				frameErr <= (state_reg == RX_STOP1) ? ~rxIn : (stopBad_reg | ~rxIn);
				breakSeen <= zeroNow;
				mpBit <= mpEn & extra_reg;
			end
		end
	end
endmodule : rx_frame_engine

// >>> uart_status_and_control.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
module uart_status_and_control #(
	parameter logic [15:0] DIV_DEFAULT = uart_pkg::DIVISOR_RESET
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [uart_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic rxPin,
	input wire logic ctsN,
	output logic txPin,
	output logic irq
);
	import uart_pkg::*;

	// Sticky flag: a set in the same cycle wins over the clear.
	function automatic logic stickyNext(input logic set, input logic flag, input logic clr);
		return set | (flag & ~clr);
	endfunction : stickyNext

	// Pin synchronisers: the first stage feeds only the second.
	logic ctsMeta_reg;
	logic ctsSync_reg;
	logic rxMeta_reg;
	logic rxSync_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctsMeta_reg <= 1'b1;
			ctsSync_reg <= 1'b1;
			rxMeta_reg <= 1'b1;
			rxSync_reg <= 1'b1;
		end else begin
			ctsMeta_reg <= ctsN;
			ctsSync_reg <= ctsMeta_reg;
			rxMeta_reg <= rxPin;
			rxSync_reg <= rxMeta_reg;
		end
	end

	logic [7:0] lineCtl_reg;
	logic [1:0] mpCtl_reg;
	logic [15:0] divisor_reg;
	logic [7:0] txHold_reg;
	logic [7:0] rxData_reg;
	logic rxAvail_reg;
	logic parityFault_reg;
	logic overrun_reg;
	logic framingFault_reg;
	logic lineBreak_reg;
	logic txHoldEmpty_reg;
	logic frameStart_reg;
	logic lastMultiproc_reg;
	logic addrSeen_reg;
	logic [IRQ_W-1:0] irqStatus_reg;
	logic [IRQ_W-1:0] irqMask_reg;

	// Bus decode.
	wire busReq = cyc_i & stb_i;
	wire accept = busReq & ~ack_o;
	wire [IDX_W-1:0] idx = adr_i[ADR_W-1:2];
	wire hitData = (idx == IDX_DATA);
	wire hitLineStatus = (idx == IDX_LINE_STATUS);
	wire hitLineCtl = (idx == IDX_LINE_CONTROL);
	wire hitMpCtl = (idx == IDX_MP_CONTROL);
	wire hitFrameStatus = (idx == IDX_FRAME_STATUS);
	wire hitDivisor = (idx == IDX_DIVISOR);
	wire hitIrqStatus = (idx == IDX_IRQ_STATUS);
	wire hitIrqMask = (idx == IDX_IRQ_MASK);
	wire wrLow = accept & we_i & sel_i[0];
	wire wrHigh = accept & we_i & sel_i[1];
	wire rdEn = accept & ~we_i;
	wire txWrite = wrLow & hitData;
	wire rxRead = rdEn & hitData;

	// Control fields.
	wire txEnableBit = lineCtl_reg[CTL_TX_EN];
	wire rxEnableBit = lineCtl_reg[CTL_REN];
	wire flowGateEnable = lineCtl_reg[CTL_FLOW];
	wire parityEnable = lineCtl_reg[CTL_PAR_EN];
	wire paritySelect = lineCtl_reg[CTL_PAR_SEL];
	wire sendBreak = lineCtl_reg[CTL_BREAK];
	wire twoStop = lineCtl_reg[CTL_STOP];
	wire loopbackEnable = lineCtl_reg[CTL_LOOP];
	wire mpEnable = mpCtl_reg[MP_ENABLE];
	wire txGo = txEnableBit & (~flowGateEnable | ~ctsSync_reg);

	// Receiver.
	wire rxDone;
	wire [7:0] rxByte;
	wire rxParityErr;
	wire rxFrameErr;
	wire rxBreak;
	wire rxMpBit;
	wire rxLine = loopbackEnable ? txPin : rxSync_reg;

	rx_frame_engine rxEngine (
		.clk(clk),
		.rstn(rstn),
		.rxIn(rxLine),
		.enable(rxEnableBit),
		.bitDiv(divisor_reg),
		.parityEn(parityEnable),
		.paritySel(paritySelect),
		.twoStop(twoStop),
		.mpEn(mpEnable),
		.done(rxDone),
		.data(rxByte),
		.parityErr(rxParityErr),
		.frameErr(rxFrameErr),
		.breakSeen(rxBreak),
		.mpBit(rxMpBit)
	);

	// Transmitter.
	tx_state_t txState_reg;
	logic [15:0] txCnt_reg;
	logic [2:0] txBitIdx_reg;
	logic [7:0] txShift_reg;
	logic txExtra_reg;
	logic txStopLeft_reg;
	logic txBit_reg;
	wire txTick = (txCnt_reg == 16'h0000);
	wire txLoad = (txState_reg == TX_IDLE) & txGo & ~txHoldEmpty_reg;
	wire txHasExtra = parityEnable | mpEnable;
	wire txParity = (^txHold_reg) ^ paritySelect;
	wire txExtraNext = mpEnable ? mpCtl_reg[MP_TX_BIT] : txParity;
	logic txIdle_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txState_reg <= TX_IDLE;
			txCnt_reg <= 16'h0000;
			txBitIdx_reg <= 3'h0;
			txShift_reg <= 8'h00;
			txExtra_reg <= 1'b0;
			txStopLeft_reg <= 1'b0;
			txBit_reg <= 1'b1;
		end else if (txState_reg == TX_IDLE) begin
			txBit_reg <= 1'b1;
			if (txLoad) begin
				txState_reg <= TX_START;
				txShift_reg <= txHold_reg;
				txExtra_reg <= txExtraNext;
				txCnt_reg <= divisor_reg;
				txBit_reg <= 1'b0;
			end
		end else if (!txTick) begin
			txCnt_reg <= txCnt_reg - 16'h0001;
		end else begin
			txCnt_reg <= divisor_reg;
			case (txState_reg)
				TX_START: begin
					txState_reg <= TX_DATA;
					txBitIdx_reg <= 3'h0;
					txBit_reg <= txShift_reg[0];
				end
				TX_DATA: begin
					txBitIdx_reg <= txBitIdx_reg + 3'h1;
					if (txBitIdx_reg == 3'h7) begin
						txState_reg <= txHasExtra ? TX_EXTRA : TX_STOP;
						txBit_reg <= txHasExtra ? txExtra_reg : 1'b1;
						txStopLeft_reg <= twoStop;
					end else begin
						txShift_reg <= {1'b0, txShift_reg[7:1]};
						txBit_reg <= txShift_reg[1];
					end
				end
				TX_EXTRA: begin
					txState_reg <= TX_STOP;
					txBit_reg <= 1'b1;
				end
				TX_STOP: begin
					txStopLeft_reg <= 1'b0;
					txState_reg <= txStopLeft_reg ? TX_STOP : TX_IDLE;
				end
				default: begin
					txState_reg <= TX_IDLE;
				end
			endcase
		end
	end

	// Line driver, forced low while a break is being sent.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txPin <= 1'b1;
		end else begin
			txPin <= sendBreak ? 1'b0 : txBit_reg;
		end
	end

	// Idle is registered so that it rises only once the stop bit has left the pin.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txIdle_reg <= 1'b1;
		end else begin
			txIdle_reg <= (txState_reg == TX_IDLE) & ~txLoad;
		end
	end

	// Configuration registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lineCtl_reg <= CTL_RESET;
			mpCtl_reg <= 2'b00;
			divisor_reg <= DIV_DEFAULT;
			irqMask_reg <= IRQ_RESET;
		end else begin
			if (wrLow && hitLineCtl) begin
				lineCtl_reg <= dat_i[7:0];
			end
			if (wrLow && hitMpCtl) begin
				mpCtl_reg <= dat_i[1:0];
			end
			if (wrLow && hitDivisor) begin
				divisor_reg[7:0] <= dat_i[7:0];
			end
			if (wrHigh && hitDivisor) begin
				divisor_reg[15:8] <= dat_i[15:8];
			end
			if (wrLow && hitIrqMask) begin
				irqMask_reg <= dat_i[IRQ_W-1:0];
			end
		end
	end

	// Transmit holding register; the flag is set again when the shifter takes the byte.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txHold_reg <= 8'h00;
			txHoldEmpty_reg <= 1'b1;
		end else if (txWrite) begin
			txHold_reg <= dat_i[7:0];
			txHoldEmpty_reg <= 1'b0;
		end else if (txLoad) begin
			txHoldEmpty_reg <= 1'b1;
		end
	end

	// Receive flags: a new frame wins over a clearing read in the same cycle.
	wire overrunHit = rxDone & rxAvail_reg & ~rxRead;
	wire overrunClr = rxRead & ~rxAvail_reg;
	wire frameStartHit = rxDone & mpEnable & addrSeen_reg & ~rxMpBit;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxData_reg <= 8'h00;
			rxAvail_reg <= 1'b0;
			parityFault_reg <= 1'b0;
			overrun_reg <= 1'b0;
			framingFault_reg <= 1'b0;
			lineBreak_reg <= 1'b0;
			lastMultiproc_reg <= 1'b0;
			addrSeen_reg <= 1'b0;
		end else begin
			if (rxDone) begin
				rxData_reg <= rxByte;
				addrSeen_reg <= mpEnable & rxMpBit;
			end
			rxAvail_reg <= stickyNext(rxDone, rxAvail_reg, rxRead);
			parityFault_reg <= stickyNext(rxDone & rxParityErr, parityFault_reg, rxRead);
			overrun_reg <= stickyNext(overrunHit, overrun_reg, overrunClr);
			framingFault_reg <= stickyNext(rxDone & rxFrameErr, framingFault_reg, rxRead);
			lineBreak_reg <= stickyNext(rxDone & rxBreak, lineBreak_reg, rxRead);
			if (rxDone) begin
				lastMultiproc_reg <= rxMpBit;
			end else if (rxRead) begin
				lastMultiproc_reg <= 1'b0;
			end
		end
	end

	// Frame-start flag: set by the first data byte after an address byte.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frameStart_reg <= 1'b0;
		end else if (frameStartHit) begin
			frameStart_reg <= 1'b1;
		end else if (rxRead) begin
			frameStart_reg <= 1'b0;
		end else if (wrLow && hitFrameStatus) begin
			frameStart_reg <= dat_i[FS_NEW_FRAME];
		end
	end

	// Interrupt events and sticky status, cleared by writing one.
	wire rxErrEvent = rxDone & (rxParityErr | rxFrameErr | rxBreak | overrunHit);
	wire [IRQ_W-1:0] irqEvent = {rxErrEvent, txLoad, rxDone};
	wire [IRQ_W-1:0] irqClear = (wrLow && hitIrqStatus) ? dat_i[IRQ_W-1:0] : IRQ_RESET;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqStatus_reg <= IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irqStatus_reg <= irqEvent | (irqStatus_reg & ~irqClear);
			irq <= |(irqStatus_reg & irqMask_reg);
		end
	end

	// Read data.
	logic [7:0] lineStatus;
	logic [7:0] frameStatus;

	always_comb begin
		lineStatus = 8'h00;
		lineStatus[LS_AVAIL] = rxAvail_reg;
		lineStatus[LS_PARITY] = parityFault_reg;
		lineStatus[LS_OVERRUN] = overrun_reg;
		lineStatus[LS_FRAMING] = framingFault_reg;
		lineStatus[LS_BREAK] = lineBreak_reg;
		lineStatus[LS_HOLD_EMPTY] = txHoldEmpty_reg;
		lineStatus[LS_TX_IDLE] = txIdle_reg;
		lineStatus[LS_CTS] = ctsSync_reg;
		frameStatus = 8'h00;
		frameStatus[FS_NEW_FRAME] = frameStart_reg;
		frameStatus[FS_MP_BIT] = lastMultiproc_reg;
	end
	wire [15:0] readWord = hitData ? {8'h00, rxData_reg} :
		hitLineStatus ? {8'h00, lineStatus} :
		hitLineCtl ? {8'h00, lineCtl_reg} :
		hitMpCtl ? {14'h0000, mpCtl_reg} :
		hitFrameStatus ? {8'h00, frameStatus} :
		hitDivisor ? divisor_reg :
		hitIrqStatus ? {13'h0000, irqStatus_reg} :
		hitIrqMask ? {13'h0000, irqMask_reg} : 16'h0000;

	// One-cycle answer for every address, mapped or not.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= accept;
			if (rdEn) begin
				dat_o <= {16'h0000, readWord};
			end
		end
	end
endmodule : uart_status_and_control

// >>> uart_status_and_control_assertions.sv
`timescale 1ns/10ps
module uart_status_and_control_assertions #(
	parameter logic [15:0] DIV_DEFAULT = uart_pkg::DIVISOR_RESET
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [uart_pkg::ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic rxPin,
	input wire logic ctsN,
	input wire logic txPin,
	input wire logic irq
);
	import uart_pkg::*;
	localparam int QUIET = 4 * (int'(DIV_DEFAULT) + 1);
	logic [7:0] ctlCopy_reg;
	logic [7:0] ctsLow_reg;
	logic [7:0] ctsSame_reg;
	logic ctsPrev_reg;
	logic [7:0] quiet_reg;
	logic clrPend_reg;
	wire taken = cyc_i && stb_i && !ack_o;
	wire [IDX_W-1:0] idx = adr_i[ADR_W-1:2];
	wire rdData = taken && !we_i && idx == IDX_DATA;
	wire rdStatus = taken && !we_i && idx == IDX_LINE_STATUS;
	wire quietRd = rdStatus && clrPend_reg && quiet_reg >= QUIET;
	wire ctlWr = taken && we_i && sel_i[0] && idx == IDX_LINE_CONTROL;
	// A pending clear is only trusted while the receive line has stayed idle since the data read.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctlCopy_reg <= 8'h00;
			ctsLow_reg <= 8'h00;
			ctsSame_reg <= 8'h00;
			ctsPrev_reg <= 1'b1;
			quiet_reg <= 8'h00;
			clrPend_reg <= 1'b0;
		end else begin
			if (ctlWr) ctlCopy_reg <= dat_i[7:0];
			ctsLow_reg <= ctsN ? 8'h00 : ctsLow_reg + {7'h00, ctsLow_reg != 8'hFF};
			ctsSame_reg <= (ctsN != ctsPrev_reg) ? 8'h00 : ctsSame_reg + {7'h00, ctsSame_reg != 8'hFF};
			ctsPrev_reg <= ctsN;
			quiet_reg <= !rxPin ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hFF};
			if (!rxPin) clrPend_reg <= 1'b0;
			else if (rdData && quiet_reg >= QUIET) clrPend_reg <= 1'b1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_ackNext; taken |=> ack_o; endproperty
	a_ackNext: assert property (p_ackNext) else $error("request without ack");
	property p_ackPulse; ack_o |=> !ack_o; endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
	property p_resetIdle; $rose(rstn) |-> txPin && !irq && !ack_o && dat_o == 32'h0; endproperty
	a_resetIdle: assert property (p_resetIdle) else $error("outputs not idle after reset");
	property p_ctsLevel; rdStatus && ctsSame_reg >= 8'h04 |=> dat_o[LS_CTS] == $past(ctsN); endproperty
	a_ctsLevel: assert property (p_ctsLevel) else $error("cts bit differs from pin");
	property p_txGate;
		$fell(txPin) && !ctlCopy_reg[CTL_BREAK] |->
			ctlCopy_reg[CTL_TX_EN] && (!ctlCopy_reg[CTL_FLOW] || ctsLow_reg >= 8'h03);
	endproperty
	a_txGate: assert property (p_txGate) else $error("transmit without enable");
	property p_parityClr; quietRd |=> !dat_o[LS_PARITY]; endproperty
	a_parityClr: assert property (p_parityClr) else $error("parity flag kept");
	property p_framingClr; quietRd |=> !dat_o[LS_FRAMING]; endproperty
	a_framingClr: assert property (p_framingClr) else $error("framing flag kept");
	property p_breakClr; quietRd |=> !dat_o[LS_BREAK]; endproperty
	a_breakClr: assert property (p_breakClr) else $error("break flag kept");
endmodule : uart_status_and_control_assertions

// >>> serial_peer.sv
`timescale 1ns/10ps
module serial_peer #(
	parameter int BIT = 4
) (
	input wire logic clk,
	input wire logic txPin,
	output logic rxPin,
	output logic ctsN
);
	logic [7:0] gotQ[$];
	logic [7:0] rxByte;
	initial rxPin = 1'b1;
	initial ctsN = 1'b1;
	task automatic setCts(input logic v);
		ctsN <= v;
	endtask : setCts
	task automatic sendBit(input logic b);
		rxPin <= b;
		repeat (BIT) @(posedge clk);
	endtask : sendBit
	// Start bit, eight data bits lowest first, optional extra bit, one stop bit, then idle mark.
	task automatic sendFrame(input logic [7:0] d, input logic hasX, input logic x, input logic st);
		sendBit(1'b0);
		for (int i = 0; i < 8; i++) sendBit(d[i]);
		if (hasX) sendBit(x);
		sendBit(st);
		rxPin <= 1'b1;
	endtask : sendFrame
	always begin
		@(posedge clk);
		if (txPin === 1'b0) begin
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk);
				rxByte[i] = txPin;
			end
			gotQ.push_back(rxByte);
			repeat (BIT) @(posedge clk);
			while (txPin !== 1'b1) @(posedge clk);
		end
	end
endmodule : serial_peer

// >>> uart_status_and_control_tb.sv
`timescale 1ns/10ps
module uart_status_and_control_tb;
	import uart_pkg::*;
	localparam logic [15:0] DIV = 16'h0003;
	localparam logic [7:0] FD[3] = '{8'h55, 8'h0F, 8'h00};
	localparam logic [1:0] FXS[3] = '{2'h3, 2'h0, 2'h0};
	localparam logic [31:0] ERR_FLAGS[3] = '{32'h40, 32'h10, 32'h18};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADR_W-1:0] adr_i = 14'h0000;
	logic [31:0] dat_i = 32'h0;
	logic we_i = 1'b0;
	logic [3:0] sel_i = 4'h0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic [31:0] dat_o;
	logic ack_o, txPin, irq, rxPin, ctsN;
	logic [31:0] rd;
	int miscompares = 0;
	int samplesChecked = 0;
	always #4 clk = ~clk;
	uart_status_and_control #(.DIV_DEFAULT(DIV)) dut (.clk(clk), .rstn(rstn), .adr_i(adr_i),
		.dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
		.ack_o(ack_o), .rxPin(rxPin), .ctsN(ctsN), .txPin(txPin), .irq(irq));
	serial_peer #(.BIT(int'(DIV) + 1)) peer (.clk(clk), .txPin(txPin), .rxPin(rxPin), .ctsN(ctsN));
	task automatic testDone;
		$display("checks %0d, mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : testDone
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : checkVal
	task automatic wb(input logic [IDX_W-1:0] idx, input logic wr, input logic [15:0] d);
		int n;
		n = 0;
		adr_i <= {idx, 2'b00};
		dat_i <= {16'h0000, d};
		we_i <= wr;
		sel_i <= 4'hF;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (n >= 50) checkVal(32'h0, 32'h1, "bus timeout");
		@(posedge clk);
	endtask : wb
	task automatic rdChk(input logic [IDX_W-1:0] idx, input logic [31:0] m, input logic [31:0] e,
		input string what);
		wb(idx, 1'b0, 16'h0000);
		checkVal(rd & m, e, what);
	endtask : rdChk
	task automatic frame(input logic [7:0] d, input logic x, input logic st);
		peer.sendFrame(d, 1'b1, x, st);
		repeat (12) @(posedge clk);
	endtask : frame
	initial begin
		int n;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rdChk(IDX_LINE_CONTROL, 32'hFF, 32'h00, "control reset");
		rdChk(IDX_FRAME_STATUS, 32'hFF, 32'h00, "frame reset");
		rdChk(IDX_LINE_STATUS, 32'hFF, 32'h07, "status reset");
		rdChk(IDX_UART1_LINE_CONTROL, 32'hFFFFFFFF, 32'h0, "unmapped");
		wb(IDX_LINE_CONTROL, 1'b1, 16'h005A);
		rdChk(IDX_LINE_CONTROL, 32'hFF, 32'h5A, "control readback");
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0000);
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0004);
		repeat (4) @(posedge clk);
		checkVal({31'h0, txPin}, 32'h0, "break level");
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0000);
		repeat (60) @(posedge clk);
		peer.gotQ.delete();
		wb(IDX_LINE_CONTROL, 1'b1, 16'h00A0);
		wb(IDX_DATA, 1'b1, 16'h003C);
		repeat (8) @(posedge clk);
		rdChk(IDX_LINE_STATUS, 32'h06, 32'h02, "held by flow gate");
		checkVal({31'h0, txPin}, 32'h1, "no start bit");
		peer.setCts(1'b0);
		repeat (8) @(posedge clk);
		rdChk(IDX_LINE_STATUS, 32'h07, 32'h04, "shifting");
		for (n = 0; peer.gotQ.size() == 0 && n < 400; n++) @(posedge clk);
		checkVal({24'h0, peer.gotQ[0]}, 32'h3C, "sent byte");
		repeat (12) @(posedge clk);
		rdChk(IDX_LINE_STATUS, 32'h06, 32'h06, "transmit done");
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0000);
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0050);
		wb(IDX_IRQ_STATUS, 1'b1, 16'h0007);
		frame(8'h55, 1'b0, 1'b1);
		checkVal({31'h0, irq}, 32'h0, "irq masked");
		rdChk(IDX_LINE_STATUS, 32'hF8, 32'h80, "clean byte");
		wb(IDX_IRQ_MASK, 1'b1, 16'h0001);
		repeat (2) @(posedge clk);
		checkVal({31'h0, irq}, 32'h1, "irq raised");
		rdChk(IDX_DATA, 32'hFF, 32'h55, "received byte");
		wb(IDX_IRQ_STATUS, 1'b1, 16'h0007);
		repeat (2) @(posedge clk);
		checkVal({31'h0, irq}, 32'h0, "irq cleared");
		for (int i = 0; i < 3; i++) begin
			frame(FD[i], FXS[i][1], FXS[i][0]);
			rdChk(IDX_LINE_STATUS, 32'h78, ERR_FLAGS[i], "error flags");
			rdChk(IDX_DATA, 32'hFF, {24'h0, FD[i]}, "error byte");
			rdChk(IDX_LINE_STATUS, 32'h78, 32'h00, "flags cleared");
		end
		frame(8'h21, 1'b0, 1'b1);
		frame(8'h42, 1'b0, 1'b1);
		rdChk(IDX_LINE_STATUS, 32'hF8, 32'hA0, "overrun set");
		rdChk(IDX_DATA, 32'hFF, 32'h42, "newest byte kept");
		rdChk(IDX_LINE_STATUS, 32'hF8, 32'h20, "overrun kept");
		wb(IDX_DATA, 1'b0, 16'h0000);
		rdChk(IDX_LINE_STATUS, 32'hF8, 32'h00, "overrun cleared");
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0000);
		wb(IDX_MP_CONTROL, 1'b1, 16'h0001);
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0040);
		frame(8'h11, 1'b1, 1'b1);
		rdChk(IDX_FRAME_STATUS, 32'hFF, 32'h01, "mp bit held");
		wb(IDX_DATA, 1'b0, 16'h0000);
		rdChk(IDX_FRAME_STATUS, 32'hFF, 32'h00, "mp bit cleared");
		frame(8'h12, 1'b0, 1'b1);
		rdChk(IDX_FRAME_STATUS, 32'hFF, 32'h02, "frame start");
		wb(IDX_DATA, 1'b0, 16'h0000);
		rdChk(IDX_FRAME_STATUS, 32'hFF, 32'h00, "frame start cleared");
		// Loopback with odd parity and two stop bits: the byte must come back clean.
		wb(IDX_LINE_CONTROL, 1'b1, 16'h0000);
		wb(IDX_MP_CONTROL, 1'b1, 16'h0000);
		wb(IDX_LINE_CONTROL, 1'b1, 16'h00DB);
		wb(IDX_DATA, 1'b1, 16'h00A7);
		repeat (80) @(posedge clk);
		rdChk(IDX_LINE_STATUS, 32'hFF, 32'h86, "loopback status");
		rdChk(IDX_DATA, 32'hFF, 32'hA7, "loopback byte");
		testDone();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		testDone();
	end
endmodule : uart_status_and_control_tb
bind uart_status_and_control uart_status_and_control_assertions #(.DIV_DEFAULT(DIV_DEFAULT)) chk (
	.clk(clk), .rstn(rstn), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .rxPin(rxPin), .ctsN(ctsN),
	.txPin(txPin), .irq(irq));
